//--- test/core_bus_model.sv
// core-side model driving the register port and the decode port
`timescale 1ns/1ps
module core_bus_model (
  // clock
  input wire logic clk_i,
  // register side
  output logic [15:0] addr_o = 16'h0000,
  output logic [7:0] wdata_o = 8'h00,
  output logic write_o = 1'b0,
  output logic read_o = 1'b0,
  input wire logic [7:0] rdata_i,
  // decode side
  output logic [15:0] core_addr_o = 16'h0000,
  output logic ext_o = 1'b0,
  input wire logic [4:0] sel_i,
  input wire logic [1:0] stretch_i
);
  // one-cycle write; lines scrambled after so stale values are never trusted
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    write_o <= 1'b1;
    @(posedge clk_i);
    write_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  // read data is taken mid-cycle after the strobe edge
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    read_o <= 1'b1;
    @(posedge clk_i);
    read_o <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    d = rdata_i;
  endtask
  // decode answer is registered one cycle after the address
  task automatic look(input logic [15:0] a, input logic e, output logic [4:0] s, output logic [1:0] t);
    @(posedge clk_i);
    core_addr_o <= a;
    ext_o <= e;
    @(posedge clk_i);
    @(negedge clk_i);
    s = sel_i;
    t = stretch_i;
  endtask
endmodule // core_bus_model

//--- test/map_control_sva.sv
// checker for the map placement control block ports
`timescale 1ns/1ps
module map_control_sva
  import map_control_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // inputs watched
  input wire logic regspace_size_switch_i,
  input wire logic single_chip_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  // outputs watched
  input wire logic [7:0] reg_rdata_o,
  input wire logic [4:0] region_sel_o,
  input wire logic [1:0] stretch_cycles_o,
  input wire logic [5:0] page_index_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // read data only in the cycle after a read strobe
  sequence rd_at(logic [5:0] o);
    reg_read_i && reg_addr_i[5:0] == o;
  endsequence
  AST_RDATA_IDLE: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
    else $error("read data outside its cycle");
  AST_SEL_ONEHOT: assert property ($onehot(region_sel_o))
    else $error("region select not one-hot");
  AST_STRETCH_SINGLE: assert property ($past(single_chip_i) |-> stretch_cycles_o == 2'h0)
    else $error("stretch in single-chip mode");
  AST_PAGE_BITS: assert property (rd_at(OFF_PAGE) |=> reg_rdata_o[7:6] == 2'h0)
    else $error("page upper bits not zero");
  AST_EXTRAS_BITS: assert property (rd_at(OFF_EXTRAS) |=> reg_rdata_o[7:4] == 4'h0)
    else $error("extras upper bits not zero");
  AST_RSVD_ZERO: assert property (rd_at(OFF_RSVD_PAGE) |=> reg_rdata_o == 8'h00)
    else $error("reserved location not zero");
  AST_REGPOS_BITS: assert property (rd_at(OFF_REG_POS) |=> (reg_rdata_o & 8'h87) == 8'h00)
    else $error("register position fixed bits set");
  AST_RAMPOS_BITS: assert property (rd_at(OFF_RAM_POS) |=> reg_rdata_o[2:1] == 2'h0)
    else $error("ram position unused bits set");
  AST_SIZE_STRAP: assert property (rd_at(OFF_SIZE_FIRST) |=> (reg_rdata_o == 8'h00 ||
    reg_rdata_o[7] == $past(regspace_size_switch_i)) && reg_rdata_o[6] == 1'b0)
    else $error("size strap not mirrored");
  // page output may only move two cycles after a page write
  AST_PAGE_FOLLOW: assert property ($changed(page_index_o) |->
    $past(reg_write_i && reg_addr_i[5:0] == OFF_PAGE, 2))
    else $error("page output moved without a write");
  CVR_PAGE_WR: cover property (reg_write_i && reg_addr_i[5:0] == OFF_PAGE);
  CVR_STRETCH3: cover property (stretch_cycles_o == 2'h3);
  CVR_EEPROM: cover property (region_sel_o == SEL_EEPROM);
endmodule // map_control_sva
bind memory_map_placement_control map_control_sva u_map_control_sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .regspace_size_switch_i(regspace_size_switch_i), .single_chip_i(single_chip_i), .reg_addr_i(reg_addr_i),
  .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
  .region_sel_o(region_sel_o), .stretch_cycles_o(stretch_cycles_o), .page_index_o(page_index_o));

//--- test/testbench.sv
// self-checking bench for the map placement control block
`timescale 1ns/1ps
module testbench;
  import map_control_pkg::*;
  localparam logic [2:0] RAM_SW = 3'h2;
  localparam logic [1:0] FL_SW = 2'h3;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] mode = 2'h0;
  logic single = 1'b0;
  logic regsw = 1'b1;
  wire logic [15:0] addr;
  wire logic [15:0] caddr;
  wire logic [7:0] wdata;
  wire logic [7:0] rdata;
  wire logic wr_s;
  wire logic rd_s;
  wire logic ext;
  wire logic [4:0] sel;
  wire logic [1:0] str;
  wire logic [5:0] page;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] d;
  logic [7:0] v;
  logic [4:0] s;
  logic [1:0] t;
  logic [5:0] offs [8] = '{6'h10, 6'h11, 6'h12, 6'h13, 6'h1C, 6'h1D, 6'h30, 6'h31};
  memory_map_placement_control #(.RAM_SIZE_SW(RAM_SW), .FLASH_SIZE_SW(FL_SW)) u_memory_map_placement_control (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .regspace_size_switch_i(regsw), .op_mode_i(mode),
    .single_chip_i(single), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
    .reg_rdata_o(rdata), .core_addr_i(caddr), .core_ext_access_i(ext), .region_sel_o(sel),
    .stretch_cycles_o(str), .page_index_o(page));
  core_bus_model u_core_bus_model (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .write_o(wr_s),
    .read_o(rd_s), .rdata_i(rdata), .core_addr_o(caddr), .ext_o(ext), .sel_i(sel), .stretch_i(str));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // expected reset view of each offset
  function automatic logic [7:0] reset_exp(input logic [5:0] o);
    case (o)
      OFF_RAM_POS: return RAM_POS_RESET;
      OFF_EE_POS: return 8'h01;
      OFF_EXTRAS: return EXTRAS_RESET;
      OFF_SIZE_FIRST: return {1'b1, 3'h1, 1'b0, RAM_SW};
      OFF_SIZE_SECOND: return {FL_SW, 6'h01};
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task automatic restart(input logic [1:0] m);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    mode <= m;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog so a stuck run still reports
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'h3C6A8626));
    restart(MODE_NORMAL);
    foreach (offs[i]) begin
      u_core_bus_model.rd({10'h000, offs[i]}, d);
      chk("reset value", reset_exp(offs[i]), d);
    end
    $display("reset values done");
    // second RAM and extras writes refused outside special mode; EEPROM base takes both; read-only places ignore writes
    u_core_bus_model.wr(16'h0010, 8'hFF);
    u_core_bus_model.wr(16'h0010, 8'h00);
    u_core_bus_model.rd(16'h0010, d);
    chk("ram_base_position", 8'hF9, d);
    u_core_bus_model.wr(16'h0012, 8'h08);
    u_core_bus_model.wr(16'h0012, 8'h11);
    u_core_bus_model.rd(16'h0012, d);
    chk("eeprom_base_position", 8'h11, d);
    u_core_bus_model.wr(16'h0013, 8'h00);
    u_core_bus_model.wr(16'h0013, 8'h0F);
    u_core_bus_model.rd(16'h0013, d);
    chk("system_extras_control", 8'h00, d);
    u_core_bus_model.wr(16'h001C, 8'h00);
    u_core_bus_model.rd(16'h001C, d);
    chk("size_info_first", reset_exp(OFF_SIZE_FIRST), d);
    u_core_bus_model.wr(16'h0031, 8'hFF);
    u_core_bus_model.rd(16'h0031, d);
    chk("reserved_after_page", 8'h00, d);
    repeat (6) begin
      v = 8'($urandom);
      u_core_bus_model.wr(16'h0030, v);
      u_core_bus_model.rd(16'h0030, d);
      chk("program_page_select", v & PAGE_MASK, d);
      chk("page_index_o", {2'h0, v[5:0]}, {2'h0, page});
    end
    $display("normal mode done");
    restart(MODE_SPECIAL);
    for (int i = 0; i < 4; i++) begin
      u_core_bus_model.wr(16'h0013, {4'h0, 2'(i), 2'h1});
      u_core_bus_model.look(16'hC000, 1'b1, s, t);
      chk("stretch_cycles_o", 8'(i), {6'h00, t});
    end
    @(posedge clk_i);
    single <= 1'b1;
    u_core_bus_model.look(16'hC000, 1'b1, s, t);
    chk("stretch single chip", 8'h00, {6'h00, t});
    @(posedge clk_i);
    single <= 1'b0;
    u_core_bus_model.wr(16'h0010, 8'h00);
    u_core_bus_model.wr(16'h0010, 8'h21);
    u_core_bus_model.rd(16'h0010, d);
    chk("ram_base_position", 8'h21, d);
    // eeprom beats flash, flash leaves when disabled, registers beat eeprom
    u_core_bus_model.wr(16'h0012, 8'h41);
    u_core_bus_model.look(16'h4000, 1'b0, s, t);
    chk("eeprom select", 8'(SEL_EEPROM), 8'(s));
    u_core_bus_model.wr(16'h0012, 8'h40);
    u_core_bus_model.look(16'h4000, 1'b0, s, t);
    chk("flash select", 8'(SEL_FLASH), 8'(s));
    u_core_bus_model.wr(16'h0013, 8'h00);
    u_core_bus_model.look(16'h4000, 1'b0, s, t);
    chk("external select", 8'(SEL_EXTERNAL), 8'(s));
    u_core_bus_model.wr(16'h0012, 8'h01);
    u_core_bus_model.look(16'h0000, 1'b0, s, t);
    chk("register priority", 8'(SEL_REGS), 8'(s));
    // 6K of RAM in an 8K window at 0x2000: high align leaves the bottom 2K free
    u_core_bus_model.look(16'h2000, 1'b0, s, t);
    chk("ram high align gap", 8'(SEL_EXTERNAL), 8'(s));
    u_core_bus_model.look(16'h3FFF, 1'b0, s, t);
    chk("ram high align top", 8'(SEL_RAM), 8'(s));
    u_core_bus_model.wr(16'h0010, 8'h20);
    u_core_bus_model.look(16'h2000, 1'b0, s, t);
    chk("ram low align base", 8'(SEL_RAM), 8'(s));
    u_core_bus_model.look(16'h3FFF, 1'b0, s, t);
    chk("ram low align top", 8'(SEL_EXTERNAL), 8'(s));
    // move the register block and follow it
    u_core_bus_model.wr(16'h0011, 8'hFF);
    u_core_bus_model.rd(16'h0011, d);
    chk("old block base", 8'h00, d);
    u_core_bus_model.rd(16'h7811, d);
    chk("regblock_base_position", 8'h78, d);
    u_core_bus_model.look(16'h7800, 1'b0, s, t);
    chk("moved block select", 8'(SEL_REGS), 8'(s));
    u_core_bus_model.wr(16'h7811, 8'h08);
    u_core_bus_model.rd(16'h0811, d);
    chk("regblock rewrite", 8'h08, d);
    // register space strap: 2K covers base plus 0x400, 1K does not
    u_core_bus_model.look(16'h0C00, 1'b0, s, t);
    chk("2K block upper half", 8'(SEL_REGS), 8'(s));
    @(posedge clk_i);
    regsw <= 1'b0;
    u_core_bus_model.rd(16'h081C, d);
    chk("size_info_first", {1'b0, 3'h1, 1'b0, RAM_SW}, d);
    u_core_bus_model.look(16'h0C00, 1'b0, s, t);
    chk("1K block upper half", 8'(SEL_EXTERNAL), 8'(s));
    $display("special mode done");
    conclude();
  end
endmodule // testbench

//--- verilog/map_control_pkg.sv
// constants for the memory map placement control register bank
package map_control_pkg;
  // register offsets within the block
  localparam logic [5:0] OFF_RAM_POS = 6'h10;
  localparam logic [5:0] OFF_REG_POS = 6'h11;
  localparam logic [5:0] OFF_EE_POS = 6'h12;
  localparam logic [5:0] OFF_EXTRAS = 6'h13;
  localparam logic [5:0] OFF_TEST_A = 6'h14;
  localparam logic [5:0] OFF_TEST_B = 6'h17;
  localparam logic [5:0] OFF_SIZE_FIRST = 6'h1C;
  localparam logic [5:0] OFF_SIZE_SECOND = 6'h1D;
  localparam logic [5:0] OFF_PAGE = 6'h30;
  localparam logic [5:0] OFF_RSVD_PAGE = 6'h31;
  // writable bit masks
  localparam logic [7:0] RAM_POS_MASK = 8'hF9;
  localparam logic [7:0] REG_POS_MASK = 8'h78;
  localparam logic [7:0] EE_BASE_MASK = 8'hF8;
  localparam logic [7:0] EE_ENABLE_MASK = 8'h01;
  localparam logic [7:0] EXTRAS_MASK = 8'h0F;
  localparam logic [7:0] PAGE_MASK = 8'h3F;
  // reset values
  localparam logic [7:0] RAM_POS_RESET = 8'h09;
  localparam logic [7:0] REG_POS_RESET = 8'h00;
  localparam logic [7:0] EXTRAS_RESET = 8'h0D;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // field positions
  localparam int RAM_ALIGN_BIT = 0;
  localparam int EE_ENABLE_BIT = 0;
  localparam int FLASH_ENABLE_BIT = 0;
  localparam int FLASH_UPPER_BIT = 1;
  localparam int STRETCH_LSB = 2;
  localparam int REGSPACE_BIT = 7;
  // region sizes and limits
  localparam logic [15:0] WINDOW_2K_MASK = 16'hF800;
  localparam logic [15:0] WINDOW_1K_MASK = 16'hFC00;
  localparam logic [15:0] FLASH_LOWER_TOP = 16'h8000;
  // operating modes
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_EMULATION = 2'h1,
    MODE_SPECIAL = 2'h2
  } op_mode_t;
  // decoder select codes, exactly one active
  typedef enum logic [4:0] {
    SEL_REGS = 5'h01,
    SEL_RAM = 5'h02,
    SEL_EEPROM = 5'h04,
    SEL_FLASH = 5'h08,
    SEL_EXTERNAL = 5'h10
  } region_sel_t;
endpackage

//--- verilog/memory_map_placement_control.sv
// register bank and address placement decoder for the core memory map
//
// Overview of operation
// - RAM position readable always; write once in normal/emulation, always in special.
// - position register writes change the memory map one cycle later.
// - RAM position bits 7:3 give RAM base address bits 15:11.
// - RAM align bit: clear aligns low at the window base, set aligns high to the window top.
// - register block position readable always; write once outside special modes.
// - register block is 1K or 2K, placed on 2K boundary in lowest 32K.
// - register position bits 6:3 plus zero bit 7 form base bits 15:11.
// - EEPROM enable always writable; EEPROM base write-once per integration option.
// - EEPROM position bits 7:3 give EEPROM base address bits 15:11.
// - EEPROM enable set decodes EEPROM at its selected base.
// - EEPROM position reset value is an integration parameter.
// - extras register: stretch 3:2, flash upper-half 1, flash enable 0, 7:4 zero.
// - size information registers are read only, showing integration configuration.
// - page register holds six-bit index in 5:0, bits 7:6 read zero.
// - all registers addressed relative to the current register block base.
// - no device pins; all ports connect to core logic only.
// - stretch field adds 0 to 3 clocks on external access, none single-chip.
// - flash enable adds flash to the map when set, removes when clear.
// - first size register mirrors integration switches; bit 7 selects 1K or 2K.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
// every port below faces other core logic only
module memory_map_placement_control
  import map_control_pkg::*;
#(
  parameter logic [7:0] EE_POS_RESET = 8'h01,
  parameter bit EE_BASE_WRITE_ONCE = 1'b0,
  parameter logic [1:0] EEPROM_SIZE_SW = 2'h1,
  parameter logic [2:0] RAM_SIZE_SW = 3'h1,
  parameter logic [1:0] FLASH_SIZE_SW = 2'h1,
  parameter logic [1:0] PAGE_SIZE_SW = 2'h1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // integration straps and mode
  input wire logic regspace_size_switch_i,
  input wire logic [1:0] op_mode_i,
  input wire logic single_chip_i,
  // register port
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [7:0] reg_rdata_o,
  // core access decode
  input wire logic [15:0] core_addr_i,
  input wire logic core_ext_access_i,
  output logic [4:0] region_sel_o,
  output logic [1:0] stretch_cycles_o,
  output logic [5:0] page_index_o
);

  // architectural registers
  logic [7:0] ram_base_position;
  logic [7:0] regblock_base_position;
  logic [7:0] eeprom_base_position;
  logic [7:0] system_extras_control;
  logic [7:0] program_page_select;
  logic ram_lock;
  logic reg_lock;
  logic ee_lock;
  logic extras_lock;
  // map copies, which lag the registers by one cycle
  logic [7:0] ram_map;
  logic [7:0] reg_map;
  logic [7:0] ee_map;
  logic [7:0] extras_map;

  logic special_mode;
  logic in_block;
  logic [5:0] offset;
  logic wr_ram;
  logic wr_reg;
  logic wr_ee;
  logic wr_extras;
  logic wr_page;
  logic [7:0] size_first;
  logic [7:0] size_second;
  logic [7:0] next_rdata;
  logic [15:0] reg_base;
  logic [15:0] reg_win_mask;
  logic [15:0] ram_win_mask;
  logic [15:0] ram_base;
  logic hit_regs;
  logic hit_ram;
  logic hit_ee;
  logic hit_flash;
  logic [15:0] ram_alloc;
  logic [15:0] ram_offset;
  logic [15:0] ram_high_start;

  // mapping window of RAM from its size switches
  function automatic logic [15:0] ram_window(input logic [2:0] sw);
    logic [15:0] m;
    m = 16'hF800;
    unique case (sw)
      3'h0: m = 16'hF800;
      3'h1: m = 16'hF000;
      3'h2, 3'h3: m = 16'hE000;
      default: m = 16'hC000;
    endcase
    return m;
  endfunction

  // upper five base bits into a 16-bit address
  function automatic logic [15:0] base_of(input logic [7:0] pos);
    return {pos[7:3], 11'h000};
  endfunction

  // strobe aimed at one offset of this block
  function automatic logic strobe_at(input logic strobe, input logic sel, input logic [5:0] off,
                                     input logic [5:0] target);
    return strobe && sel && (off == target);
  endfunction

  // address falls in a window of the given mask placed at base
  function automatic logic in_window(input logic [15:0] addr, input logic [15:0] mask,
                                     input logic [15:0] base);
    return (addr & mask) == base;
  endfunction

  // mode code 3 counts as non-special, so the locks stay strict
  assign special_mode = (op_mode_i == MODE_SPECIAL);

  // block follows the lagged register block base
  assign reg_base = base_of(reg_map & REG_POS_MASK);
  // the block spans 64 offsets above the register base
  assign in_block = in_window(reg_addr_i, 16'hFFC0, reg_base);
  assign offset = reg_addr_i[5:0];

  // write strobes per offset; writes outside the block fall through silently
  assign wr_ram = strobe_at(reg_write_i, in_block, offset, OFF_RAM_POS);
  assign wr_reg = strobe_at(reg_write_i, in_block, offset, OFF_REG_POS);
  assign wr_ee = strobe_at(reg_write_i, in_block, offset, OFF_EE_POS);
  assign wr_extras = strobe_at(reg_write_i, in_block, offset, OFF_EXTRAS);
  assign wr_page = strobe_at(reg_write_i, in_block, offset, OFF_PAGE);

  // RAM position, write once outside special modes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ram_base_position <= RAM_POS_RESET;
    end else if (wr_ram && (special_mode || !ram_lock)) begin
      ram_base_position <= reg_wdata_i & RAM_POS_MASK;
    end
  end

  // register block position, same write policy
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regblock_base_position <= REG_POS_RESET;
    end else if (wr_reg && (special_mode || !reg_lock)) begin
      // bit 7 is forced to zero
      regblock_base_position <= reg_wdata_i & REG_POS_MASK;
    end
  end

  // enable always writable, base per integration option
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      eeprom_base_position <= EE_POS_RESET & (EE_BASE_MASK | EE_ENABLE_MASK);
    end else if (wr_ee) begin
      // the enable bit never locks, so the EEPROM can be parked at any time
      eeprom_base_position[EE_ENABLE_BIT] <= reg_wdata_i[EE_ENABLE_BIT];
      if (!EE_BASE_WRITE_ONCE || special_mode || !ee_lock) begin
        eeprom_base_position[7:3] <= reg_wdata_i[7:3];
      end
    end
  end

  // all four extras bits share one lock, set by the first write outside special mode
  // extras fields, write once outside special modes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      system_extras_control <= EXTRAS_RESET;
    end else if (wr_extras && (special_mode || !extras_lock)) begin
      system_extras_control <= reg_wdata_i & EXTRAS_MASK;
    end
  end

  // the page index never locks; it moves on every bank switch
  // six-bit page index
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      program_page_select <= PAGE_RESET;
    end else if (wr_page) begin
      program_page_select <= reg_wdata_i & PAGE_MASK;
    end
  end

  // a write attempt outside special mode locks even when it is refused
  // RAM position lock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ram_lock <= 1'b0;
    end else if (wr_ram && !special_mode) begin
      ram_lock <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_lock <= 1'b0;
    end else if (wr_reg && !special_mode) begin
      reg_lock <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ee_lock <= 1'b0;
    end else if (wr_ee && !special_mode) begin
      ee_lock <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      extras_lock <= 1'b0;
    end else if (wr_extras && !special_mode) begin
      extras_lock <= 1'b1;
    end
  end

  // the decoder reads only these copies, never the live registers
  // RAM map lag
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ram_map <= RAM_POS_RESET;
    end else begin
      ram_map <= ram_base_position;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_map <= REG_POS_RESET;
    end else begin
      reg_map <= regblock_base_position;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ee_map <= EE_POS_RESET & (EE_BASE_MASK | EE_ENABLE_MASK);
    end else begin
      ee_map <= eeprom_base_position;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      extras_map <= EXTRAS_RESET;
    end else begin
      extras_map <= system_extras_control;
    end
  end

  // size straps never change, so no lag copy is kept
  // first size register mirrors the switches
  assign size_first = {regspace_size_switch_i, 1'b0, EEPROM_SIZE_SW, 1'b0, RAM_SIZE_SW};
  assign size_second = {FLASH_SIZE_SW, 4'h0, PAGE_SIZE_SW};

  // read mux; test and reserved locations read zero
  always_comb begin
    next_rdata = 8'h00;
    if (in_block) begin
      // only offsets inside the block at the lagged base answer
      unique case (offset)
        OFF_RAM_POS: next_rdata = ram_base_position;
        OFF_REG_POS: next_rdata = regblock_base_position;
        OFF_EE_POS: next_rdata = eeprom_base_position;
        OFF_EXTRAS: next_rdata = system_extras_control;
        OFF_SIZE_FIRST: next_rdata = size_first;
        OFF_SIZE_SECOND: next_rdata = size_second;
        OFF_PAGE: next_rdata = program_page_select;
        OFF_RSVD_PAGE: next_rdata = 8'h00;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // zero outside the read cycle lets the core merge read buses with a plain or
  // read data one cycle after the strobe, held otherwise at zero
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_read_i) begin
      reg_rdata_o <= next_rdata;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // register window is 1K or 2K, base on a 2K boundary
  // compared against the lagged base, as the register port is
  assign reg_win_mask = size_first[REGSPACE_BIT] ? WINDOW_2K_MASK : WINDOW_1K_MASK;
  assign hit_regs = in_window(core_addr_i, reg_win_mask, reg_base);

  // RAM base from upper bits, trimmed to the mappable window
  // the size switches are fixed, so the window terms fold to constants
  assign ram_win_mask = ram_window(RAM_SIZE_SW);
  assign ram_base = base_of(ram_map) & ram_win_mask;
  // allocated RAM is (switch + 1) times 2K and may be smaller than its window
  assign ram_alloc = {2'h0, RAM_SIZE_SW, 11'h000} + 16'h0800;
  assign ram_offset = core_addr_i & ~ram_win_mask;
  // first used offset when aligned high; window size is the inverted mask plus one
  assign ram_high_start = (~ram_win_mask) + 16'h0001 - ram_alloc;
  // align bit picks low or high end of the window
  assign hit_ram = in_window(core_addr_i, ram_win_mask, ram_base) &&
                   (ram_map[RAM_ALIGN_BIT] ? (ram_offset >= ram_high_start) : (ram_offset < ram_alloc));

  // EEPROM base upper bits; decoded only when enabled
  // the EEPROM window is fixed at 2K; a larger array needs a wider mask here
  assign hit_ee = ee_map[EE_ENABLE_BIT] && in_window(core_addr_i, WINDOW_2K_MASK, base_of(ee_map));

  // flash sits last in priority, so its wide decode never steals an access
  // flash decoded only when enabled; upper-half limit applies
  assign hit_flash = extras_map[FLASH_ENABLE_BIT] &&
                     (core_addr_i >= FLASH_LOWER_TOP || !extras_map[FLASH_UPPER_BIT]);

  // registered select trades one cycle of latency for a glitch-free one-hot output
  // priority decode, one select per access
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      region_sel_o <= SEL_EXTERNAL;
    end else if (hit_regs) begin
      region_sel_o <= SEL_REGS;
    end else if (hit_ram) begin
      region_sel_o <= SEL_RAM;
    end else if (hit_ee) begin
      region_sel_o <= SEL_EEPROM;
    end else if (hit_flash) begin
      region_sel_o <= SEL_FLASH;
    end else begin
      region_sel_o <= SEL_EXTERNAL;
    end
  end

  // registered with the select, so both describe the same access
  // stretch applies to external accesses only, not single chip
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stretch_cycles_o <= 2'h0;
    end else if (core_ext_access_i && !single_chip_i) begin
      stretch_cycles_o <= extras_map[STRETCH_LSB +: 2];
    end else begin
      stretch_cycles_o <= 2'h0;
    end
  end

  // page index out to the expansion logic
  // registered so the page never glitches in mid-access
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      page_index_o <= 6'h00;
    end else begin
      page_index_o <= program_page_select[5:0];
    end
  end

endmodule // memory_map_placement_control
